/* rtl/motor_driver_control_regs.sv */
// control register bank of the three-phase motor driver with its serial port
`include "motor_regs_defines.svh"

module motor_driver_control_regs import motor_regs_pkg::*; #(
  parameter int unsigned RETRY_SHORT_CYC = `RETRY_SHORT_MS * `CLK_KHZ,
  parameter int unsigned RETRY_LONG_CYC = `RETRY_LONG_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  // fault sources and PWM cycle edge from driver logic
  input wire logic overcurrent_det,
  input wire logic thermal_warn_det,
  input wire logic pwm_cycle_edge,
  // fault reporting and bridge control
  output logic fault_pin_n,
  output logic bridge_hiz,
  // drive configuration
  output logic [1:0] pwm_scheme,
  output logic [1:0] slew_rate,
  output logic full_duty_fast,
  output logic ov_level_low,
  output logic ov_guard_en,
  // overcurrent configuration
  output logic oc_threshold_high,
  output logic [1:0] oc_filter_time,
  // sense and rectification configuration
  output logic limit_coast,
  output logic async_rect_en,
  output logic sync_rect_en,
  output logic [1:0] sense_gain
);

  // synchronised pins and edge history
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic sclk_d_r;
  logic cs_n_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic active;

  // frame shifters
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic sdo_bit_r;

  // register storage
  logic [7:1] drive_r;
  logic [6:0] prot_r;
  logic [7:0] ocs_r;
  logic [7:0] sense_r;
  logic [2:0] lock_code_r;
  logic lock_r;
  logic clear_pulse_r;

  // decode and fault state
  logic [5:0] rd_addr;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] status_byte;
  logic frame_ok;
  logic wr_addr_ok;
  logic wr_go;
  logic cfg_wr;
  logic framing_err;
  logic addr_err;
  logic oc_fault_r;
  logic spi_fault_r;
  logic oc_set;
  logic oc_clr;
  logic oc_hold;
  logic retry_start;
  logic retry_busy;
  logic retry_done;
  oc_response_t oc_mode;

  // pins come from the host's domain
  sync2 #(.WIDTH(3), .INIT(3'h2)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({sclk, cs_n, sdi}),
    .q({sclk_s, cs_n_s, sdi_s})
  );

  // edge history of the synchronised pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign frame_start = ~cs_n_s & cs_n_d_r;
  assign frame_end = cs_n_s & ~cs_n_d_r;
  assign active = ~cs_n_s;

  // bit counter saturates so long frames stay flagged as framing errors
  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    if (bit_cnt_r != 5'h1F)
      bit_cnt_nxt = bit_cnt_r + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bit_cnt_r <= 5'h00;
    else if (frame_start)
      bit_cnt_r <= 5'h00;
    else if (active && sclk_fall)
      bit_cnt_r <= bit_cnt_nxt;
  end

  // receive on falling sclk, msb first
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_r <= 16'h0000;
    else if (active && sclk_fall)
      rx_r <= {rx_r[14:0], sdi_s};
  end

  // transmit: status byte first, read data spliced in once the address is known
  always_ff @(posedge clk)
  begin
    if (rst)
      tx_r <= 16'h0000;
    else if (frame_start)
      tx_r <= {status_byte, 8'h00};
    else if (active && sclk_rise)
      tx_r <= {tx_r[14:0], 1'b0};
    else if (active && sclk_fall && bit_cnt_nxt == `ADDR_DONE_BITS)
      tx_r <= {rd_data, tx_r[7:0]};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sdo_bit_r <= 1'b1;
    else if (active && sclk_rise)
      sdo_bit_r <= tx_r[15];
  end

  // open-drain only pulls low; push-pull drives both levels while selected
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else if (drive_r[`B_SDO_DRIVE])
    begin
      sdo_out <= sdo_bit_r;
      sdo_oe <= active;
    end
    else
    begin
      sdo_out <= 1'b0;
      sdo_oe <= active & ~sdo_bit_r;
    end
  end

  // read address from the first byte, write fields from the whole frame
  assign rd_addr = rx_r[5:0]; // seven bits in at the eighth fall: rw flag above the address
  assign wr_addr = rx_r[14:9];
  assign wr_data = rx_r[7:0];

  assign status_byte = {3'h0, retry_busy, bridge_hiz, thermal_warn_det, spi_fault_r, oc_fault_r};

  // read mux; the clear strobe always reads back zero
  always_comb
  begin
    unique case (rd_addr)
      `OFS_FAULT_STATUS: rd_data = status_byte;
      `OFS_LOCK: rd_data = {5'h00, lock_code_r};
      `OFS_DRIVE_SETUP: rd_data = {drive_r, 1'b0};
      `OFS_PROTECTION_SETUP: rd_data = {1'b0, prot_r};
      `OFS_OVERCURRENT_SETUP: rd_data = ocs_r;
      `OFS_SENSE_SETUP: rd_data = sense_r;
      default: rd_data = 8'h00;
    endcase
  end

  // write commit happens at deselect of a clean frame
  assign frame_ok = frame_end && (bit_cnt_r == `FRAME_BITS);
  assign wr_addr_ok = (wr_addr == `OFS_FAULT_STATUS) || (wr_addr == `OFS_LOCK) ||
                      (wr_addr == `OFS_DRIVE_SETUP) || (wr_addr == `OFS_PROTECTION_SETUP) ||
                      (wr_addr == `OFS_OVERCURRENT_SETUP) || (wr_addr == `OFS_SENSE_SETUP);
  assign wr_go = frame_ok && !rx_r[15] && wr_addr_ok;
  assign cfg_wr = wr_go && !lock_r;
  assign framing_err = frame_end && (bit_cnt_r != `FRAME_BITS);
  assign addr_err = frame_ok && !wr_addr_ok;

  // lock code register stays writable while locked
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_code_r <= `RST_LOCK;
      lock_r <= 1'b0;
    end
    else if (wr_go && wr_addr == `OFS_LOCK)
    begin
      lock_code_r <= wr_data[2:0];
      if (wr_data[2:0] == `LOCK_CODE_OPEN)
        lock_r <= 1'b0;
      else if (wr_data[2:0] == `LOCK_CODE_SHUT)
        lock_r <= 1'b1;
    end
  end

  // drive_setup; strobe bit is not stored, only pulsed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive_r <= 7'(`RST_DRIVE_SETUP >> 1);
      clear_pulse_r <= 1'b0;
    end
    else
    begin
      clear_pulse_r <= cfg_wr && wr_addr == `OFS_DRIVE_SETUP && wr_data[`B_FAULT_CLEAR];
      if (cfg_wr && wr_addr == `OFS_DRIVE_SETUP)
        drive_r <= wr_data[7:1];
    end
  end

  // protection_setup, top bit reads zero
  always_ff @(posedge clk)
  begin
    if (rst)
      prot_r <= 7'(`RST_PROTECTION_SETUP);
    else if (cfg_wr && wr_addr == `OFS_PROTECTION_SETUP)
      prot_r <= 7'(wr_data & `PROT_WR_MASK);
  end

  // overcurrent_setup
  always_ff @(posedge clk)
  begin
    if (rst)
      ocs_r <= `RST_OVERCURRENT_SETUP;
    else if (cfg_wr && wr_addr == `OFS_OVERCURRENT_SETUP)
      ocs_r <= wr_data;
  end

  // sense_and_rectify_setup
  always_ff @(posedge clk)
  begin
    if (rst)
      sense_r <= `RST_SENSE_SETUP;
    else if (cfg_wr && wr_addr == `OFS_SENSE_SETUP)
      sense_r <= wr_data;
  end

  // overcurrent response decode
  assign oc_mode = oc_response_t'(ocs_r[`B_OC_RESP_LO +: 2]);
  assign oc_set = overcurrent_det && (oc_mode != OC_IGNORE);
  assign oc_clr = clear_pulse_r || retry_done ||
                  (ocs_r[`B_CYCLE_CLR] && pwm_cycle_edge);
  assign oc_hold = oc_fault_r && (oc_mode == OC_LATCH || oc_mode == OC_RETRY);
  assign retry_start = oc_fault_r && (oc_mode == OC_RETRY) && !retry_busy &&
                       !retry_done; // expiring wait must not rearm on the fault it clears

  // set beats clear so a persisting fault relatches at once
  always_ff @(posedge clk)
  begin
    if (rst)
      oc_fault_r <= 1'b0;
    else if (oc_set)
      oc_fault_r <= 1'b1;
    else if (oc_clr)
      oc_fault_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      spi_fault_r <= 1'b0;
    else if (framing_err || addr_err)
      spi_fault_r <= 1'b1;
    else if (clear_pulse_r)
      spi_fault_r <= 1'b0;
  end

  retry_timer #(.SHORT_CYC(RETRY_SHORT_CYC), .LONG_CYC(RETRY_LONG_CYC)) u_retry (
    .clk(clk),
    .rst(rst),
    .start(retry_start),
    .long_sel(ocs_r[`B_RETRY_INT]),
    .busy(retry_busy),
    .done(retry_done)
  );

  // fault pin and bridge state, registered so the pins never glitch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_pin_n <= 1'b1;
      bridge_hiz <= 1'b0;
    end
    else
    begin
      fault_pin_n <= ~(oc_fault_r ||
                       (spi_fault_r && !prot_r[`B_SPI_REP_OFF]) ||
                       (thermal_warn_det && prot_r[`B_THERM_REP]));
      bridge_hiz <= ocs_r[`B_BRIDGE_OFF] || oc_hold;
    end
  end

  // configuration fields straight from register flops
  assign pwm_scheme = drive_r[`B_SCHEME_LO +: 2];
  assign slew_rate = drive_r[`B_SLEW_LO +: 2];
  assign full_duty_fast = prot_r[`B_FULL_DUTY];
  assign ov_level_low = prot_r[`B_OV_LEVEL];
  assign ov_guard_en = prot_r[`B_OV_GUARD];
  assign oc_threshold_high = ocs_r[`B_OC_THRESH];
  assign oc_filter_time = ocs_r[`B_OC_FILT_LO +: 2];
  assign limit_coast = sense_r[`B_RECIRC];
  assign async_rect_en = sense_r[`B_ASYNC_RECT];
  assign sync_rect_en = sense_r[`B_SYNC_RECT];
  assign sense_gain = sense_r[`B_GAIN_LO +: 2];

endmodule // motor_driver_control_regs

/* include/motor_regs_defines.svh */
// offsets, field positions, reset values and timing counts of the motor driver control bank
//
// Summary of operation
// - writing one to fault_clear_strobe clears latched faults; bit self-returns to zero
// - input scheme field: 0 six-input, 1 six+limit, 2 three-input, 3 three+limit
// - serial_out_drive_select clear gives open-drain output, set push-pull; resets push-pull
// - edge rate field codes 0..3 select 25, 50, 125, 200 V/us
// - full duty refresh bit selects 20 kHz when clear, 40 kHz when set
// - overvoltage_level_select gives 34 V when clear, 22 V when set
// - overvoltage_guard clear disables protection, set enables; resets enabled
// - serial_fault_report_off clear lets serial faults pull fault_pin_n; resets set
// - thermal warning drives fault_pin_n only when thermal_warning_report set; resets clear
// - bridge_disable set puts all output FETs in high impedance
// - overcurrent_cycle_clear set clears pending overcurrent at next PWM cycle change
// - overcurrent_filter_time codes 0..3 give 0.2, 0.6, 1.25, 1.6 us; resets 1
// - auto-retry waits 5 ms when retry_interval clear, 500 ms when set
// - overcurrent_response: 0 latch, 1 auto-retry, 2 report only, 3 ignore
// - limit_recirculation_path clear brakes through FETs, set coasts through diodes
// - async_rectify set enables asynchronous active rectification
// - sync_rectify set enables synchronous active rectification
// - sense_amplifier_gain codes 0..3 give 0.15, 0.3, 0.6, 1.2 V/A
// - lock code 011b unlocks registers; 110b locks all but the lock code
`ifndef MOTOR_REGS_DEFINES_SVH
`define MOTOR_REGS_DEFINES_SVH

// register offsets
`define OFS_FAULT_STATUS 6'h00
`define OFS_LOCK 6'h03
`define OFS_DRIVE_SETUP 6'h04
`define OFS_PROTECTION_SETUP 6'h05
`define OFS_OVERCURRENT_SETUP 6'h06
`define OFS_SENSE_SETUP 6'h07

// reset values
`define RST_DRIVE_SETUP 8'h60
`define RST_PROTECTION_SETUP 8'h46
`define RST_OVERCURRENT_SETUP 8'h10
`define RST_SENSE_SETUP 8'h00
`define RST_LOCK 3'h0

// lock codes
`define LOCK_CODE_OPEN 3'h3
`define LOCK_CODE_SHUT 3'h6

// drive_setup fields
`define B_FAULT_CLEAR 0
`define B_SCHEME_LO 1
`define B_SLEW_LO 3
`define B_SDO_DRIVE 5
// protection_setup fields
`define B_THERM_REP 0
`define B_SPI_REP_OFF 1
`define B_OV_GUARD 2
`define B_OV_LEVEL 3
`define B_FULL_DUTY 4
`define PROT_WR_MASK 8'h7F
// overcurrent_setup fields
`define B_OC_RESP_LO 0
`define B_OC_THRESH 2
`define B_RETRY_INT 3
`define B_OC_FILT_LO 4
`define B_CYCLE_CLR 6
`define B_BRIDGE_OFF 7
// sense_and_rectify_setup fields
`define B_GAIN_LO 0
`define B_SYNC_RECT 2
`define B_ASYNC_RECT 3
`define B_RECIRC 6

// serial frame
`define FRAME_BITS 5'h10
`define ADDR_DONE_BITS 5'h08

// timing
`define CLK_KHZ 40000
`define RETRY_SHORT_MS 5
`define RETRY_LONG_MS 500

`endif

/* include/motor_regs_pkg.sv */
// types shared by the motor driver control bank
package motor_regs_pkg;

  typedef enum logic [1:0] {
    SCHEME_SIX = 2'h0,
    SCHEME_SIX_LIMIT = 2'h1,
    SCHEME_THREE = 2'h2,
    SCHEME_THREE_LIMIT = 2'h3
  } pwm_scheme_t;

  typedef enum logic [1:0] {
    OC_LATCH = 2'h0,
    OC_RETRY = 2'h1,
    OC_REPORT = 2'h2,
    OC_IGNORE = 2'h3
  } oc_response_t;

  typedef enum logic {
    RT_IDLE = 1'b0,
    RT_COUNT = 1'b1
  } retry_state_t;

endpackage

/* rtl/sync2.sv */
// two-flop synchroniser, one chain per bit
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      // first flop feeds only the second
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta_r <= INIT[i];
          q[i] <= INIT[i];
        end
        else
        begin
          meta_r <= d[i];
          q[i] <= meta_r;
        end
      end
    end
  endgenerate

endmodule // sync2

/* rtl/retry_timer.sv */
// overcurrent auto-retry interval timer
module retry_timer import motor_regs_pkg::*; #(
  parameter int unsigned SHORT_CYC = 200000,
  parameter int unsigned LONG_CYC = 20000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic long_sel,
  // status
  output logic busy,
  output logic done
);

  retry_state_t state_r;
  logic [24:0] cnt_r;
  logic [24:0] limit_r;

  // interval latched at start so a mid-wait setting change cannot stretch it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= RT_IDLE;
      cnt_r <= 25'h0000000;
      limit_r <= 25'h0000000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state_r)
        RT_IDLE:
        begin
          if (start)
          begin
            state_r <= RT_COUNT;
            cnt_r <= 25'h0000000;
            limit_r <= long_sel ? 25'(LONG_CYC - 1) : 25'(SHORT_CYC - 1);
          end
        end
        RT_COUNT:
        begin
          if (cnt_r == limit_r)
          begin
            state_r <= RT_IDLE;
            done <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 25'h0000001;
        end
      endcase
    end
  end

  assign busy = (state_r == RT_COUNT);

endmodule // retry_timer

/* dv/spi_host_model.sv */
// serial bus host model that frames accesses into the control bank
module spi_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // serial clock stands still low outside frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // msb first; 6 clocks a level so the device synchronisers see every edge
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n <= 1'b0;
    hold(6);
    for (int i = 0; i < nbits; i++)
    begin
      sclk <= 1'b1;
      sdi <= word[15-i];
      hold(6);
      rx = {rx[14:0], sdo_line};
      sclk <= 1'b0;
      hold(6);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi; // released line must not keep a stale bit
    hold(10);
  endtask
endmodule // spi_host_model

/* dv/motor_regs_sva.sv */
// port-level checks for the motor driver control bank
module motor_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic overcurrent_det,
  input wire logic fault_pin_n,
  input wire logic bridge_hiz,
  // configuration
  input wire logic [1:0] pwm_scheme,
  input wire logic [1:0] slew_rate,
  input wire logic full_duty_fast,
  input wire logic ov_level_low,
  input wire logic ov_guard_en,
  input wire logic oc_threshold_high,
  input wire logic [1:0] oc_filter_time,
  input wire logic limit_coast,
  input wire logic async_rect_en,
  input wire logic sync_rect_en,
  input wire logic [1:0] sense_gain
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // reset leaves guard on, filter code 1, no fault, bridge live
  property p_reset_vals;
    $fell(rst) |-> ov_guard_en && oc_filter_time == 2'h1 && fault_pin_n && !bridge_hiz;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
  // output driver idle when deselected
  property p_sdo_idle;
    cs_n [*8] |-> !sdo_oe;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");
  property p_sdo_rise;
    $rose(sdo_oe) |-> !$past(cs_n, 2);
  endproperty
  a_sdo_rise: assert property (p_sdo_rise) else $error("sdo enabled unselected");
  // settings move only once a frame has closed
  property p_drive_cfg;
    !$stable({pwm_scheme, slew_rate}) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_drive_cfg: assert property (p_drive_cfg) else $error("drive moved in frame");
  property p_prot_cfg;
    !$stable({full_duty_fast, ov_level_low, ov_guard_en}) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_prot_cfg: assert property (p_prot_cfg) else $error("prot moved");
  property p_oc_cfg;
    !$stable({oc_threshold_high, oc_filter_time}) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_oc_cfg: assert property (p_oc_cfg) else $error("oc moved in frame");
  property p_sense_cfg;
    !$stable({limit_coast, async_rect_en, sync_rect_en, sense_gain}) |-> $past(cs_n, 2);
  endproperty
  a_sense_cfg: assert property (p_sense_cfg) else $error("sense moved");
  // bridge goes off only from an overcurrent or a committed write
  property p_hiz_cause;
    $rose(bridge_hiz) |-> $past(overcurrent_det, 2) || (cs_n && $past(cs_n, 2));
  endproperty
  a_hiz_cause: assert property (p_hiz_cause) else $error("bridge off uncaused");
endmodule // motor_regs_sva

bind motor_driver_control_regs motor_regs_sva u_motor_regs_sva (.clk, .rst, .cs_n, .sdo_oe,
  .overcurrent_det, .fault_pin_n, .bridge_hiz, .pwm_scheme, .slew_rate, .full_duty_fast,
  .ov_level_low, .ov_guard_en, .oc_threshold_high, .oc_filter_time, .limit_coast,
  .async_rect_en, .sync_rect_en, .sense_gain);

/* dv/testbench.sv */
// self-checking bench for the motor driver control bank
`include "motor_regs_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus into the bank
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic overcurrent_det = 1'b0;
  logic thermal_warn_det = 1'b0;
  logic pwm_cycle_edge = 1'b0;
  // pins and configuration outputs
  logic sclk, cs_n, sdi, sdo_out, sdo_oe, sdo_line, fault_pin_n, bridge_hiz;
  logic full_duty_fast, ov_level_low, ov_guard_en, oc_threshold_high;
  logic limit_coast, async_rect_en, sync_rect_en;
  logic [1:0] pwm_scheme, slew_rate, oc_filter_time, sense_gain;
  logic [15:0] rx;
  logic [7:0] rst_tab [4] = '{8'h60, 8'h46, 8'h10, 8'h00};
  logic [1:0] early [4] = '{2'h2, 2'h2, 2'h0, 2'h1};
  logic [1:0] late [4] = '{2'h2, 2'h1, 2'h0, 2'h1};
  int num_errors = 0;
  int check_count = 0;
  int oe_cnt = 0;

  always #12.5 clk = ~clk;
  // enable-high cycles tell push-pull from open-drain
  always @(posedge clk) oe_cnt <= oe_cnt + int'(sdo_oe);
  assign sdo_line = sdo_oe ? sdo_out : 1'b1; // pull-up when undriven

  motor_driver_control_regs #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(50))
    u_motor_driver_control_regs (.clk, .rst, .sclk, .cs_n, .sdi, .sdo_out, .sdo_oe,
    .overcurrent_det, .thermal_warn_det, .pwm_cycle_edge, .fault_pin_n, .bridge_hiz,
    .pwm_scheme, .slew_rate, .full_duty_fast, .ov_level_low, .ov_guard_en,
    .oc_threshold_high, .oc_filter_time, .limit_coast, .async_rect_en, .sync_rect_en,
    .sense_gain);
  spi_host_model u_spi_host_model (.clk, .sclk, .cs_n, .sdi, .sdo_line);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_spi_host_model.xfer({1'b0, a, 1'b0, d}, 16, rx);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    u_spi_host_model.xfer({1'b1, a, 9'h000}, 16, rx);
    d = rx[7:0];
  endtask
  task automatic oc_hit();
    overcurrent_det <= 1'b1;
    cyc(1);
    overcurrent_det <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    logic [7:0] v;
    int c0;
    cyc(3);
    rst <= 1'b0;
    cyc(4);
    `CHK({ov_guard_en, oc_filter_time, fault_pin_n, bridge_hiz}, 5'h16)
    for (int i = 0; i < 4; i++)
    begin
      c0 = oe_cnt;
      rd(6'(4 + i), v);
      `CHK(v, rst_tab[i])
      `CHK(oe_cnt - c0 > 180, 1'b1)
    end
    $display("test reset done");
    // every field code; the strobe must read back as zero
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFS_DRIVE_SETUP, {3'b011, 2'(c), 2'(3 - c), 1'b1});
      `CHK({slew_rate, pwm_scheme}, {2'(c), 2'(3 - c)})
      rd(`OFS_DRIVE_SETUP, v);
      `CHK(v, {3'b011, 2'(c), 2'(3 - c), 1'b0})
      wr(`OFS_OVERCURRENT_SETUP, {2'b00, 2'(c), 1'b0, c[0], 2'b11});
      wr(`OFS_SENSE_SETUP, {1'b0, c[0], 2'b00, c[1], c[0], 2'(c)});
      wr(`OFS_PROTECTION_SETUP, {3'b010, c[0], c[1], ~c[0], 2'b10});
      `CHK({oc_threshold_high, oc_filter_time}, {c[0], 2'(c)})
      `CHK({limit_coast, async_rect_en, sync_rect_en, sense_gain}, {c[0], c[1], c[0], 2'(c)})
      `CHK({full_duty_fast, ov_level_low, ov_guard_en}, {c[0], c[1], ~c[0]})
    end
    // lock keeps settings until unlocked
    wr(`OFS_LOCK, 8'h06);
    wr(`OFS_SENSE_SETUP, 8'h00);
    rd(`OFS_SENSE_SETUP, v);
    `CHK({v, sense_gain}, 10'h13F)
    wr(`OFS_LOCK, 8'h03);
    wr(`OFS_SENSE_SETUP, 8'hFE);
    `CHK(sense_gain, 2'h2)
    wr(`OFS_OVERCURRENT_SETUP, 8'h93);
    `CHK(bridge_hiz, 1'b1)
    wr(`OFS_OVERCURRENT_SETUP, 8'h13);
    `CHK(bridge_hiz, 1'b0)
    // open-drain: ones come from the pull-up, so far fewer driven cycles
    wr(`OFS_DRIVE_SETUP, 8'h40);
    c0 = oe_cnt;
    rd(`OFS_SENSE_SETUP, v);
    `CHK({v, oe_cnt - c0 < 150}, 9'h1FD)
    wr(`OFS_DRIVE_SETUP, 8'h60);
    $display("test config done");
    // overcurrent responses, then the clear strobe
    wr(`OFS_PROTECTION_SETUP, 8'h46);
    for (int m = 0; m < 4; m++)
    begin
      wr(`OFS_OVERCURRENT_SETUP, 8'h10 | 8'(m));
      oc_hit();
      cyc(12);
      `CHK({bridge_hiz, fault_pin_n}, early[m])
      cyc(30);
      `CHK({bridge_hiz, fault_pin_n}, late[m])
      wr(`OFS_DRIVE_SETUP, 8'h61);
      `CHK({bridge_hiz, fault_pin_n}, 2'h1)
    end
    wr(`OFS_OVERCURRENT_SETUP, 8'h19);
    oc_hit();
    cyc(40);
    `CHK(bridge_hiz, 1'b1)
    cyc(30);
    `CHK(bridge_hiz, 1'b0)
    // a condition that outlasts the clear sets the bit again
    wr(`OFS_OVERCURRENT_SETUP, 8'h12);
    overcurrent_det <= 1'b1;
    wr(`OFS_DRIVE_SETUP, 8'h61);
    `CHK(fault_pin_n, 1'b0)
    overcurrent_det <= 1'b0;
    wr(`OFS_DRIVE_SETUP, 8'h61);
    `CHK(fault_pin_n, 1'b1)
    for (int k = 0; k < 2; k++)
    begin
      wr(`OFS_OVERCURRENT_SETUP, {1'b0, k[0], 6'h12});
      oc_hit();
      cyc(4);
      pwm_cycle_edge <= 1'b1;
      cyc(1);
      pwm_cycle_edge <= 1'b0;
      cyc(4);
      `CHK(fault_pin_n, k[0])
      wr(`OFS_DRIVE_SETUP, 8'h61);
    end
    $display("test overcurrent done");
    // thermal warning and serial faults on the fault pin
    thermal_warn_det <= 1'b1;
    cyc(4);
    `CHK(fault_pin_n, 1'b1)
    wr(`OFS_PROTECTION_SETUP, 8'h47);
    `CHK(fault_pin_n, 1'b0)
    thermal_warn_det <= 1'b0;
    u_spi_host_model.xfer(16'h0A55, 15, rx);
    rd(`OFS_FAULT_STATUS, v);
    `CHK({v, fault_pin_n}, 9'h005)
    wr(`OFS_PROTECTION_SETUP, 8'h44);
    `CHK(fault_pin_n, 1'b0)
    wr(`OFS_DRIVE_SETUP, 8'h61);
    `CHK(fault_pin_n, 1'b1)
    rd(6'h10, v);
    `CHK({v, fault_pin_n}, 9'h000)
    $display("test fault pin done");
    close_out();
  end

  // hang guard: the run needs well under a millisecond
  initial
  begin
    #2ms;
    num_errors++;
    close_out();
  end
endmodule // testbench
